//--- core_model.sv
// Model of the core and the event sources around the sleep controller
`timescale 1ns/1ns
module core_model (
	// Clock
	input wire logic clk,
	// Controller outputs
	input sleep_ctrl_pkg::power_ctl_t powerCtl,
	// Core requests and events
	output sleep_ctrl_pkg::core_req_t coreReq,
	output logic extEvent,
	output logic peerSendEvent
);
	int slow = 0;
	initial begin
		coreReq = '0;
		extEvent = 1'b0;
		peerSendEvent = 1'b0;
	end
	// A halted core issues no instruction
	task automatic pulse(input int b);
		wait (powerCtl.coreHalt === 1'b0);
		repeat (slow) @(posedge clk);
		@(posedge clk);
		coreReq[b] <= 1'b1;
		@(posedge clk);
		coreReq[b] <= 1'b0;
	endtask
	task automatic level(input int b, input logic v);
		@(posedge clk);
		coreReq[b] <= v;
	endtask
	// Event input or send-event from another processor
	task automatic evt(input logic peer);
		@(posedge clk);
		if (peer) peerSendEvent <= 1'b1;
		else extEvent <= 1'b1;
		repeat (3) @(posedge clk);
		peerSendEvent <= 1'b0;
		extEvent <= 1'b0;
	endtask
endmodule

//--- core_sleep_wakeup_control.sv
// Sleep entry, wakeup and clock gating control for the processor core
`timescale 1ns/1ns
`include "sleep_ctrl_map.svh"
module core_sleep_wakeup_control #(
	parameter int unsigned PLL_LOCK_CYC = `SC_PLL_LOCK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core side, same clock
	input sleep_ctrl_pkg::core_req_t coreReq,
	// Event sources from outside
	input wire logic extEvent,
	input wire logic peerSendEvent,
	// Power and clock control
	output sleep_ctrl_pkg::power_ctl_t powerCtl
);
	// =========================================================
	// Reset release and input synchronisers
	logic rstMeta;
	logic rstN;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN <= rstMeta;
		end
	end

	logic extSync;
	logic peerSync;
	sync2 uExtSync (
		.clk(clk),
		.rstN(rstN),
		.d(extEvent),
		.q(extSync)
	);
	sync2 uPeerSync (
		.clk(clk),
		.rstN(rstN),
		.d(peerSendEvent),
		.q(peerSync)
	);

	// =========================================================
	// State
	typedef struct packed {
		sleep_ctrl_pkg::sleep_state_t state;
		sleep_ctrl_pkg::entry_t entry;
		logic eventLatch;
		logic deep;
		logic extPrev;
		logic peerPrev;
		logic sleepAfter;
		logic deepSel;
		logic pendEvt;
		logic [31:0] rdata;
		logic deferred;
	} state_t;

	state_t cur;
	state_t next_cur;

	logic pllStart;
	logic pllDone;
	delay_count #(
		.LOAD(PLL_LOCK_CYC)
	) uPllWait (
		.clk(clk),
		.rstN(rstN),
		.start(pllStart),
		.done(pllDone)
	);

	logic extRise;
	logic peerRise;
	logic evtWake;
	logic excWake;
	logic wakeNow;
	logic apbWr;
	logic apbRd;
	logic sleeping;

	// =========================================================
	// Next state
	always_comb begin
		next_cur = cur;
		pllStart = 1'b0;
		extRise = extSync && !cur.extPrev;
		peerRise = peerSync && !cur.peerPrev;
		next_cur.extPrev = extSync;
		next_cur.peerPrev = peerSync;
		apbWr = psel && penable && pwrite;
		apbRd = psel && !penable && !pwrite;
		sleeping = (cur.state == sleep_ctrl_pkg::ST_LIGHT) ||
			(cur.state == sleep_ctrl_pkg::ST_DEEP);
		excWake = coreReq.excReady;
		evtWake = extRise || peerRise;
		if (cur.pendEvt && coreReq.newPend) begin
			evtWake = 1'b1;
		end
		if (cur.entry == sleep_ctrl_pkg::ENTRY_WAIT_EVT) begin
			wakeNow = excWake || evtWake;
		end else begin
			wakeNow = excWake;
		end

		// Registers
		if (apbWr && paddr == `SC_ADDR_CTRL && pstrb[0]) begin
			next_cur.sleepAfter = pwdata[`SC_CTRL_SLEEP_AFTER];
			next_cur.deepSel = pwdata[`SC_CTRL_DEEP];
			next_cur.pendEvt = pwdata[`SC_CTRL_PEND_EVT];
		end
		if (apbRd) begin
			next_cur.rdata = 32'h00000000;
			if (paddr == `SC_ADDR_CTRL) begin
				next_cur.rdata[`SC_CTRL_SLEEP_AFTER] = cur.sleepAfter;
				next_cur.rdata[`SC_CTRL_DEEP] = cur.deepSel;
				next_cur.rdata[`SC_CTRL_PEND_EVT] = cur.pendEvt;
			end else if (paddr == `SC_ADDR_STATUS) begin
				next_cur.rdata[2:0] = cur.state;
				next_cur.rdata[`SC_ST_LATCH] = cur.eventLatch;
				next_cur.rdata[`SC_ST_DEEP] = cur.deep;
			end
		end

		// Event latch set while awake
		if (!sleeping && (extRise || peerRise)) begin
			next_cur.eventLatch = 1'b1;
		end

		unique case (cur.state)
			sleep_ctrl_pkg::ST_RUN: begin
				next_cur.entry = sleep_ctrl_pkg::ENTRY_NONE;
				if (coreReq.waitEvt) begin
					if (cur.eventLatch || extRise || peerRise) begin
						next_cur.eventLatch = 1'b0;
					end else begin
						next_cur.entry = sleep_ctrl_pkg::ENTRY_WAIT_EVT;
					end
				end else if (coreReq.waitInt && !excWake) begin
					next_cur.entry = sleep_ctrl_pkg::ENTRY_WAIT_INT;
				end else if (coreReq.lastReturn && cur.sleepAfter) begin
					next_cur.entry = sleep_ctrl_pkg::ENTRY_EXIT;
				end
				if (next_cur.entry != sleep_ctrl_pkg::ENTRY_NONE) begin
					next_cur.deep = cur.deepSel;
					if (cur.deepSel) begin
						next_cur.state = sleep_ctrl_pkg::ST_DEEP;
					end else begin
						next_cur.state = sleep_ctrl_pkg::ST_LIGHT;
					end
				end
				if (cur.deferred && !coreReq.priorityMask) begin
					next_cur.deferred = 1'b0;
				end
			end
			sleep_ctrl_pkg::ST_LIGHT: begin
				if (wakeNow) begin
					next_cur.state = sleep_ctrl_pkg::ST_RESUME;
				end
			end
			sleep_ctrl_pkg::ST_DEEP: begin
				if (wakeNow) begin
					pllStart = 1'b1;
					next_cur.state = sleep_ctrl_pkg::ST_PWRUP;
				end
			end
			sleep_ctrl_pkg::ST_PWRUP: begin
				if (pllDone) begin
					next_cur.state = sleep_ctrl_pkg::ST_RESUME;
				end
			end
			sleep_ctrl_pkg::ST_RESUME: begin
				next_cur.state = sleep_ctrl_pkg::ST_RUN;
				next_cur.entry = sleep_ctrl_pkg::ENTRY_NONE;
				next_cur.deep = 1'b0;
				next_cur.deferred = coreReq.priorityMask &&
					!coreReq.fault_mask_bit;
			end
			default: begin
				next_cur.state = sleep_ctrl_pkg::ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cur <= '{state: sleep_ctrl_pkg::ST_RUN,
				entry: sleep_ctrl_pkg::ENTRY_NONE,
				rdata: 32'h00000000, default: 1'b0};
		end else begin
			cur <= next_cur;
		end
	end

	// =========================================================
	// Outputs
	assign pready = 1'b1;
	assign pslverr = psel && penable && (paddr != `SC_ADDR_CTRL) &&
		(paddr != `SC_ADDR_STATUS);
	assign prdata = cur.rdata;

	always_comb begin
		powerCtl.coreClkEn = (cur.state == sleep_ctrl_pkg::ST_RUN) ||
			(cur.state == sleep_ctrl_pkg::ST_RESUME);
		powerCtl.sysClkEn = (cur.state != sleep_ctrl_pkg::ST_DEEP);
		powerCtl.pllEn = (cur.state != sleep_ctrl_pkg::ST_DEEP);
		powerCtl.flashEn = (cur.state != sleep_ctrl_pkg::ST_DEEP);
		powerCtl.coreHalt = !powerCtl.coreClkEn;
		powerCtl.skipUnstack = (cur.entry == sleep_ctrl_pkg::ENTRY_EXIT);
		powerCtl.deferHandler = cur.deferred;
	end

	// =========================================================
	// Checks
	property pDeepStops;
		@(posedge clk) disable iff (!rstN)
		cur.state == sleep_ctrl_pkg::ST_DEEP |->
			!powerCtl.sysClkEn && !powerCtl.pllEn && !powerCtl.flashEn;
	endproperty
	AST_DEEP_OFF: assert property (pDeepStops)
		else $error("Deep sleep left clocks running");

	AST_LIGHT_CORE: assert property (@(posedge clk) disable iff (!rstN)
		cur.state == sleep_ctrl_pkg::ST_LIGHT |->
			!powerCtl.coreClkEn && powerCtl.sysClkEn)
		else $error("Light sleep clock gating wrong");

	AST_LEVEL_SEL: assert property (@(posedge clk) disable iff (!rstN)
		cur.state == sleep_ctrl_pkg::ST_RUN && next_cur.entry !=
			sleep_ctrl_pkg::ENTRY_NONE |=> cur.deep == $past(cur.deepSel))
		else $error("Sleep level not taken from select bit");

	AST_WFE_CLEAR: assert property (@(posedge clk) disable iff (!rstN)
		cur.state == sleep_ctrl_pkg::ST_RUN && coreReq.waitEvt &&
			cur.eventLatch |=> cur.state == sleep_ctrl_pkg::ST_RUN &&
			!cur.eventLatch)
		else $error("Event wait with latch set did not clear and run");

	AST_WFE_SLEEP: assert property (@(posedge clk) disable iff (!rstN)
		cur.state == sleep_ctrl_pkg::ST_RUN && coreReq.waitEvt &&
			!cur.eventLatch && !extRise && !peerRise |=>
			powerCtl.coreHalt)
		else $error("Event wait with latch clear did not sleep");

	AST_WFI_SLEEP: assert property (@(posedge clk) disable iff (!rstN)
		cur.state == sleep_ctrl_pkg::ST_RUN && coreReq.waitInt &&
			!coreReq.waitEvt && !coreReq.excReady |=> powerCtl.coreHalt)
		else $error("Interrupt wait did not sleep");

	AST_EVT_SET: assert property (@(posedge clk) disable iff (!rstN)
		cur.state == sleep_ctrl_pkg::ST_RUN && !coreReq.waitEvt &&
			extRise |=> cur.eventLatch)
		else $error("Event input did not set latch");

	AST_WFI_HOLD: assert property (@(posedge clk) disable iff (!rstN)
		cur.state == sleep_ctrl_pkg::ST_LIGHT && cur.entry ==
			sleep_ctrl_pkg::ENTRY_WAIT_INT && !coreReq.excReady |=>
			cur.state == sleep_ctrl_pkg::ST_LIGHT)
		else $error("Interrupt-wait sleep woke without exception");

	// Cycles spent waiting for the PLL to lock
	logic [17:0] pwrupCnt;
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pwrupCnt <= 18'h00000;
		end else if (cur.state == sleep_ctrl_pkg::ST_PWRUP) begin
			pwrupCnt <= pwrupCnt + 18'h00001;
		end else begin
			pwrupCnt <= 18'h00000;
		end
	end

	sequence sWake;
		cur.state == sleep_ctrl_pkg::ST_DEEP && wakeNow;
	endsequence
	AST_DEEP_RESUME: assert property (@(posedge clk) disable iff (!rstN)
		sWake |=> cur.state == sleep_ctrl_pkg::ST_PWRUP &&
			powerCtl.pllEn && powerCtl.sysClkEn)
		else $error("Deep sleep did not restore clocks");

	AST_PWRUP_BOUND: assert property (@(posedge clk) disable iff (!rstN)
		cur.state == sleep_ctrl_pkg::ST_PWRUP |->
			pwrupCnt <= 18'(PLL_LOCK_CYC))
		else $error("Power-up wait ran past the PLL lock time");

	AST_PEND_WAKE: assert property (@(posedge clk) disable iff (!rstN)
		cur.state == sleep_ctrl_pkg::ST_LIGHT && cur.entry ==
			sleep_ctrl_pkg::ENTRY_WAIT_EVT && cur.pendEvt &&
			coreReq.newPend |=> cur.state == sleep_ctrl_pkg::ST_RESUME)
		else $error("Pending interrupt did not wake event wait");
endmodule

//--- delay_count.sv
// Down-counter that flags when a wait has run out
`timescale 1ns/1ns
module delay_count #(
	parameter int unsigned LOAD = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstN,
	// Control
	input wire logic start,
	output logic done
);
	logic [17:0] count;
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			count <= 18'h00000;
		end else if (start) begin
			count <= 18'(LOAD);
		end else if (count != 18'h00000) begin
			count <= count - 18'h00001;
		end
	end
	assign done = (count == 18'h00000) && !start;
endmodule

//--- sleep_ctrl_map.svh
// Register offsets, field positions and reset values of the sleep controller
`ifndef SLEEP_CTRL_MAP_SVH
`define SLEEP_CTRL_MAP_SVH
`define SC_ADDR_CTRL 12'h000
`define SC_ADDR_STATUS 12'h004
`define SC_CTRL_SLEEP_AFTER 1
`define SC_CTRL_DEEP 2
`define SC_CTRL_PEND_EVT 4
`define SC_CTRL_RESET 32'h00000000
`define SC_ST_STATE_LO 0
`define SC_ST_LATCH 4
`define SC_ST_DEEP 5
`define SC_PLL_LOCK_NS 200000
`define SC_CLK_NS 50
`define SC_PLL_LOCK_CYC ((`SC_PLL_LOCK_NS + `SC_CLK_NS - 1) / `SC_CLK_NS)
`define SC_FLASH_WAKE_NS 1000
`define SC_FLASH_WAKE_CYC ((`SC_FLASH_WAKE_NS + `SC_CLK_NS - 1) / `SC_CLK_NS)
`endif

//--- sleep_ctrl_pkg.sv
// Types shared by the sleep controller
package sleep_ctrl_pkg;
	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_LIGHT = 3'h1,
		ST_DEEP = 3'h2,
		ST_PWRUP = 3'h3,
		ST_RESUME = 3'h4
	} sleep_state_t;

	typedef enum logic [1:0] {
		ENTRY_NONE = 2'h0,
		ENTRY_WAIT_INT = 2'h1,
		ENTRY_WAIT_EVT = 2'h2,
		ENTRY_EXIT = 2'h3
	} entry_t;

	typedef struct packed {
		logic waitInt;
		logic waitEvt;
		logic lastReturn;
		logic excReady;
		logic newPend;
		logic priorityMask;
		logic fault_mask_bit;
	} core_req_t;

	typedef struct packed {
		logic coreClkEn;
		logic sysClkEn;
		logic pllEn;
		logic flashEn;
		logic coreHalt;
		logic skipUnstack;
		logic deferHandler;
	} power_ctl_t;
endpackage

//--- sync2.sv
// Two-flop synchroniser for one level
`timescale 1ns/1ns
module sync2 (
	// Clock and reset
	input wire logic clk,
	input wire logic rstN,
	// Level
	input wire logic d,
	output logic q
);
	logic [1:0] stage;
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			stage <= 2'h0;
		end else begin
			stage <= {stage[0], d};
		end
	end
	assign q = stage[1];
endmodule

//--- tb_core_sleep_wakeup_control.sv
// Self-checking bench of the sleep controller
`timescale 1ns/1ns
module tb_core_sleep_wakeup_control;
	localparam int WI = 6, WE = 5, LR = 4, EX = 3, NP = 2, PM = 1;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, ctrl;
	logic [3:0] pstrb;
	sleep_ctrl_pkg::core_req_t coreReq;
	sleep_ctrl_pkg::power_ctl_t powerCtl;
	logic extEvent, peerSendEvent;
	int n_errors = 0, n_compared = 0, cyc = 0, expLatch = 0;
	core_sleep_wakeup_control #(.PLL_LOCK_CYC(8)) dut_u (.clk(clk),
		.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .coreReq(coreReq),
		.extEvent(extEvent), .peerSendEvent(peerSendEvent),
		.powerCtl(powerCtl));
	core_model u_core (.clk(clk), .powerCtl(powerCtl), .coreReq(coreReq),
		.extEvent(extEvent), .peerSendEvent(peerSendEvent));
	// ==========================
	// Clock, timeout, report
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic final_report();
		if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// ==========================
	// APB master
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		if (pslverr === 1'b1) rd = 32'hffffffff;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic stat(input int st);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd & 32'h17, 32'(st) | 32'(expLatch << 4));
	endtask
	task automatic waitHalt(input logic h);
		int i;
		i = 0;
		#1;
		while (powerCtl.coreHalt !== h && i < 40) begin
			@(posedge clk);
			#1;
			i++;
		end
		chk(32'(powerCtl.coreHalt), 32'(h));
	endtask
	// ==========================
	// Tests
	initial begin
		nrst = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		void'($urandom(56443));
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		stat(0);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'hffffffff);
		ctrl = $urandom & 32'h16;
		u_core.slow = $urandom_range(0, 2);
		apb(1'b1, 12'h000, ctrl);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, ctrl);
		apb(1'b1, 12'h000, 32'h0);
		for (int p = 0; p < 2; p++) begin
			u_core.evt(p[0]);
			repeat (5) @(posedge clk);
			expLatch = 1;
			stat(0);
			u_core.pulse(WE);
			waitHalt(1'b0);
			expLatch = 0;
			stat(0);
		end
		u_core.pulse(WE);
		waitHalt(1'b1);
		chk(32'(powerCtl[6:3]), 32'h7);
		stat(1);
		u_core.evt(1'b1);
		waitHalt(1'b0);
		stat(0);
		u_core.level(EX, 1'b1);
		u_core.pulse(WI);
		repeat (3) @(posedge clk);
		waitHalt(1'b0);
		u_core.level(EX, 1'b0);
		u_core.pulse(WI);
		waitHalt(1'b1);
		u_core.evt(1'b0);
		u_core.level(NP, 1'b1);
		u_core.level(NP, 1'b0);
		repeat (4) @(posedge clk);
		waitHalt(1'b1);
		u_core.level(EX, 1'b1);
		waitHalt(1'b0);
		u_core.level(EX, 1'b0);
		stat(0);
		apb(1'b1, 12'h000, 32'h4);
		u_core.pulse(WI);
		waitHalt(1'b1);
		chk(32'(powerCtl[6:3]), 32'h0);
		u_core.level(EX, 1'b1);
		waitHalt(1'b0);
		chk(32'(powerCtl[6:3]), 32'hf);
		u_core.level(EX, 1'b0);
		apb(1'b1, 12'h000, 32'h2);
		u_core.pulse(LR);
		waitHalt(1'b1);
		chk(32'(powerCtl.skipUnstack), 32'h1);
		u_core.level(EX, 1'b1);
		waitHalt(1'b0);
		u_core.level(EX, 1'b0);
		apb(1'b1, 12'h000, 32'h10);
		u_core.pulse(WE);
		waitHalt(1'b1);
		u_core.level(NP, 1'b1);
		u_core.level(NP, 1'b0);
		waitHalt(1'b0);
		apb(1'b1, 12'h000, 32'h0);
		u_core.level(PM, 1'b1);
		u_core.pulse(WI);
		waitHalt(1'b1);
		u_core.level(EX, 1'b1);
		waitHalt(1'b0);
		@(posedge clk);
		#1;
		chk(32'(powerCtl.deferHandler), 32'h1);
		u_core.level(PM, 1'b0);
		repeat (3) @(posedge clk);
		chk(32'(powerCtl.deferHandler), 32'h0);
		u_core.level(EX, 1'b0);
		final_report();
	end
endmodule
